// >>> bench/rsm_host.sv
// Host model driving the register port
`timescale 1ns/100ps
`default_nettype none
module rsm_host (
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid,
  output logic            reg_wr = 1'b0,
  output logic            reg_rd = 1'b0,
  output logic      [7:0] reg_addr = 8'h00,
  output logic      [7:0] reg_wdata = 8'h00
);
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    @(posedge clock);
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule
`default_nettype wire

// >>> bench/rsm_monitor.sv
// Concurrent checks on the status and mask block ports
`timescale 1ns/100ps
`default_nettype none
module rsm_monitor (
  // Watched ports
  input wire logic       clock,
  input wire logic       arst_n,
  input wire logic       conv1_on_flag,
  input wire logic       linreg0_current_limiting_raw,
  input wire logic       power_ok_pin_state,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Last host mask write
  logic [7:0] wmask;
  logic       wseen;
  wire        mask_wr = reg_wr && reg_addr == 8'h20;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) wseen <= 1'b0;
    else if (mask_wr) wseen <= 1'b1;
  end
  always_ff @(posedge clock) begin
    if (mask_wr) wmask <= reg_wdata;
  end
  AST_RVALID: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  AST_IDLE: assert property (!reg_rd |=> !reg_rvalid && $stable(reg_rdata))
    else $error("read data moved without a read");
  AST_CONV_ON: assert property (($stable(conv1_on_flag)[*2] ##0 reg_rd && reg_addr == 8'h1e)
    |=> reg_rdata[7] == $past(conv1_on_flag)) else $error("converter enable bit wrong");
  AST_LIN_LIM: assert property (($stable(linreg0_current_limiting_raw)[*4] ##0 reg_rd
    && reg_addr == 8'h1f) |=> reg_rdata[0] == $past(linreg0_current_limiting_raw))
    else $error("linear limit bit wrong");
  AST_PWR_RAW: assert property (($stable(power_ok_pin_state)[*4] ##0 reg_rd
    && reg_addr == 8'h31) |=> reg_rdata[7] == $past(power_ok_pin_state))
    else $error("raw power good bit wrong");
  AST_MASK_RD: assert property (wseen && reg_rd && reg_addr == 8'h20 |=> reg_rdata == wmask)
    else $error("mask readback wrong");
  AST_MASK_IRQ: assert property (mask_wr && reg_wdata == 8'hff |=> ##1 !irq)
    else $error("irq with all masked");
  AST_UNMAP: assert property (reg_rd && reg_addr == 8'h40 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  cover property (irq);
  cover property (mask_wr);
  cover property (reg_rvalid && reg_rdata != 8'h00);
endmodule
bind rsm_top rsm_monitor u_rsm_monitor (.clock(clock), .arst_n(arst_n),
  .conv1_on_flag(conv1_on_flag), .linreg0_current_limiting_raw(linreg0_current_limiting_raw),
  .power_ok_pin_state(power_ok_pin_state), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .irq(irq));
`default_nettype wire

// >>> bench/test_rsm_top.sv
// Self-checking bench for the status and mask block
`timescale 1ns/100ps
`default_nettype none
module test_rsm_top;
  `define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED at %0t: %s", $time, m); end end
  logic       clock = 1'b0;
  logic       arst_n = 1'b0;
  logic [5:0] cv = 6'h00;
  logic [5:0] lr = 6'h00;
  logic [3:0] tp = 4'h0;
  logic [7:0] fm = 8'h5a;
  logic       reg_wr, reg_rd, reg_rvalid, irq, ok;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, ex;
  int         bad_count = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  always #12.5 clock = ~clock;
  rsm_top u_rsm_top (.clock, .arst_n, .conv1_on_flag(cv[5]), .conv1_vout_bad_raw(cv[4]),
    .conv1_current_limiting_raw(cv[3]), .conv0_on_flag(cv[2]), .conv0_vout_bad_raw(cv[1]),
    .conv0_current_limiting_raw(cv[0]), .linreg1_on_flag(lr[5]), .linreg1_vout_bad_raw(lr[4]),
    .linreg1_current_limiting_raw(lr[3]), .linreg0_on_flag(lr[2]),
    .linreg0_vout_bad_raw(lr[1]), .linreg0_current_limiting_raw(lr[0]),
    .power_ok_pin_state(tp[3]), .sync_clock_invalid(tp[2]), .thermal_warning_state(tp[1]),
    .load_measure_ready(tp[0]), .factory_mask(fm), .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .irq);
  rsm_host u_rsm_host (.clock, .reg_rdata, .reg_rvalid, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata);
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic t_reset();
    u_rsm_host.rd(8'h20, rv, ok);
    `CHK(ok, 1'b1, "no read answer")
    `CHK(rv, fm, "factory mask")
    $display("reset test done");
  endtask
  task automatic t_status();
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      cv <= i ? 6'h15 : 6'h2a;
      lr <= i ? 6'h2a : 6'h15;
      u_rsm_host.wr(8'h1f, 8'hff);
      u_rsm_host.rd(8'h1e, rv, ok);
      ex = {cv[5:4], 1'b0, cv[3:1], 1'b0, cv[0]};
      `CHK(rv, ex, "converter status")
      u_rsm_host.rd(8'h1f, rv, ok);
      ex = {lr[5:4], 1'b0, lr[3:1], 1'b0, lr[0]};
      `CHK(rv, ex, "linear status")
    end
    $display("status test done");
  endtask
  task automatic t_events();
    int b[4] = '{7, 4, 2, 0};
    for (int k = 0; k < 4; k++) begin
      u_rsm_host.wr(8'h20, 8'hff);
      tp[3-k] <= ~tp[3-k];
      repeat (6) @(posedge clock);
      #1;
      `CHK(irq, 1'b0, "masked event raised irq")
      u_rsm_host.rd(8'h31, rv, ok);
      ex = {tp[3], 2'b00, tp[2], 1'b0, tp[1], 1'b0, tp[0]};
      `CHK(rv, ex, "raw top status")
      u_rsm_host.rd(8'h30, rv, ok);
      `CHK(rv, 8'h01 << b[k], "event flag")
      u_rsm_host.wr(8'h20, ~(8'h01 << b[k]));
      repeat (2) @(posedge clock);
      #1;
      `CHK(irq, 1'b1, "unmasked event no irq")
      u_rsm_host.rd(8'h20, rv, ok);
      `CHK(rv, ~(8'h01 << b[k]), "mask readback")
      u_rsm_host.wr(8'h30, 8'hff);
      u_rsm_host.rd(8'h30, rv, ok);
      `CHK(rv, 8'h00, "flag not cleared")
      `CHK(irq, 1'b0, "irq after clear")
    end
    u_rsm_host.rd(8'h40, rv, ok);
    `CHK(rv, 8'h00, "unmapped read")
    $display("event test done");
  endtask
  task automatic t_rereset();
    @(posedge clock);
    fm     <= 8'ha5;
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    `CHK(irq, 1'b0, "irq in reset")
    `CHK(reg_rdata, 8'h00, "read data in reset")
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
    u_rsm_host.rd(8'h20, rv, ok);
    `CHK(rv, 8'ha5, "factory mask after reset")
    u_rsm_host.rd(8'h30, rv, ok);
    `CHK(rv, 8'h00, "false event after reset")
    `CHK(irq, 1'b0, "irq after reset")
    $display("second reset test done");
  endtask
  initial begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
    t_reset();
    t_status();
    t_events();
    t_rereset();
    give_verdict();
  end
endmodule
`default_nettype wire

// >>> rtl/rsm_pkg.sv
// Constants and types for the regulator status and interrupt mask block
// What this block does
// - Each switching converter's enable state reads as bit 7 (converter 1) and bit 3 (converter 0), 1 meaning enabled.
// - Each switching converter's raw output-voltage validity reads at bit 6 and bit 2, 1 meaning invalid.
// - Each switching converter's raw current-limit state reads at bit 4 and bit 0, 1 while limiting.
// - Each linear regulator's enable state reads at bit 7 and bit 3 of the linear status register at 0x1f.
// - Each linear regulator's raw output-voltage validity reads at bit 6 and bit 2, 1 meaning invalid.
// - Each linear regulator's raw current-limit state reads at bit 4 and bit 0, 1 while limiting.
// - Mask bit 7 at 0x20 blocks the power-good interrupt when 1.
// - The power-good mask never changes the raw power-good pin status.
// - Mask bit 4 blocks the external clock interrupt when 1.
// - The external clock mask never changes the raw clock validity status.
// - Mask bit 2 blocks the thermal warning interrupt when 1.
// - The thermal warning mask never changes the raw thermal warning status.
// - Mask bit 0 blocks the load measurement ready interrupt when 1.
// - Each event is latched in a flag that stays set until the host writes 1 to it.
package rsm_pkg;
  localparam int         DATA_W          = 8;
  localparam int         ADDR_W          = 8;
  localparam logic [7:0] ADDR_CONV_STAT  = 8'h1e;
  localparam logic [7:0] ADDR_LIN_STAT   = 8'h1f;
  localparam logic [7:0] ADDR_TOP_MASK   = 8'h20;
  localparam logic [7:0] ADDR_EVENT_FLAG = 8'h30;
  localparam logic [7:0] ADDR_RAW_TOP    = 8'h31;
  localparam int         BIT_ON1         = 7;
  localparam int         BIT_BAD1        = 6;
  localparam int         BIT_LIM1        = 4;
  localparam int         BIT_ON0         = 3;
  localparam int         BIT_BAD0        = 2;
  localparam int         BIT_LIM0        = 0;
  localparam int         BIT_PWR_OK      = 7;
  localparam int         BIT_SYNC_CLK    = 4;
  localparam int         BIT_THERMAL     = 2;
  localparam int         BIT_LOAD_MEAS   = 0;
  // Edges after reset before the event detector sees real pin levels
  localparam int         SETTLE_EDGES    = 3;
  localparam logic [7:0] MASK_USED       = 8'h95;
  localparam logic [7:0] ZERO_BYTE       = 8'h00;
  typedef logic [DATA_W-1:0] rsm_byte_t;
endpackage

// >>> rtl/rsm_status_if.sv
// Raw status bundle passed from the synchroniser to the register file
`timescale 1ns/100ps
`default_nettype none
interface rsm_status_if;
  logic [5:0] conv;
  logic [5:0] linreg;
  logic [3:0] top;
  modport src (output conv, output linreg, output top);
  modport dst (input conv, input linreg, input top);
endinterface
`default_nettype wire

// >>> rtl/rsm_sync.sv
// Two-stage synchroniser for the raw status inputs
`timescale 1ns/100ps
`default_nettype none
module rsm_sync (
  // Clock and reset
  input  wire logic  clock,
  input  wire logic  arst_n,
  // Raw pins
  input  wire logic [15:0] raw_in,
  // Synchronised bundle
  rsm_status_if.src  st
);
  logic [15:0] stage1;
  logic [15:0] stage2;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= raw_in;
      stage2 <= stage1;
    end
  end

  assign st.conv   = stage2[5:0];
  assign st.linreg = stage2[11:6];
  assign st.top    = stage2[15:12];
endmodule
`default_nettype wire

// >>> rtl/rsm_top.sv
// Regulator status registers, top event mask and interrupt request
`timescale 1ns/100ps
`default_nettype none
module rsm_top
  import rsm_pkg::*;
(
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 arst_n,
  // Switching converter raw status
  input  wire logic                 conv1_on_flag,
  input  wire logic                 conv0_on_flag,
  input  wire logic                 conv1_vout_bad_raw,
  input  wire logic                 conv0_vout_bad_raw,
  input  wire logic                 conv1_current_limiting_raw,
  input  wire logic                 conv0_current_limiting_raw,
  // Linear regulator raw status
  input  wire logic                 linreg1_on_flag,
  input  wire logic                 linreg0_on_flag,
  input  wire logic                 linreg1_vout_bad_raw,
  input  wire logic                 linreg0_vout_bad_raw,
  input  wire logic                 linreg1_current_limiting_raw,
  input  wire logic                 linreg0_current_limiting_raw,
  // Top-level raw status
  input  wire logic                 power_ok_pin_state,
  input  wire logic                 sync_clock_invalid,
  input  wire logic                 thermal_warning_state,
  input  wire logic                 load_measure_ready,
  // Factory mask values
  input  wire logic [DATA_W-1:0]    factory_mask,
  // Register port from the serial interface
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [ADDR_W-1:0]    reg_addr,
  input  wire logic [DATA_W-1:0]    reg_wdata,
  output logic      [DATA_W-1:0]    reg_rdata,
  output logic                      reg_rvalid,
  // Interrupt request
  output logic                      irq
);
  import rsm_pkg::*;

  // --------------------------------------------------------------
  // Input synchronisation
  // --------------------------------------------------------------
  rsm_status_if st ();

  rsm_sync u_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .raw_in ({load_measure_ready, thermal_warning_state, sync_clock_invalid,
              power_ok_pin_state,
              linreg1_on_flag, linreg1_vout_bad_raw, linreg1_current_limiting_raw,
              linreg0_on_flag, linreg0_vout_bad_raw, linreg0_current_limiting_raw,
              conv1_on_flag, conv1_vout_bad_raw, conv1_current_limiting_raw,
              conv0_on_flag, conv0_vout_bad_raw, conv0_current_limiting_raw}),
    .st     (st)
  );

  // --------------------------------------------------------------
  // Status layout
  // --------------------------------------------------------------
  function automatic rsm_byte_t pack_stat(input logic [5:0] s);
    rsm_byte_t b;
    b           = ZERO_BYTE;
    b[BIT_ON1]  = s[5];
    b[BIT_BAD1] = s[4];
    b[BIT_LIM1] = s[3];
    b[BIT_ON0]  = s[2];
    b[BIT_BAD0] = s[1];
    b[BIT_LIM0] = s[0];
    return b;
  endfunction

  wire rsm_byte_t conv_stat = pack_stat(st.conv);
  wire rsm_byte_t lin_stat  = pack_stat(st.linreg);

  // Raw top status: masks never touch these bits
  rsm_byte_t raw_top;
  always_comb begin
    raw_top                = ZERO_BYTE;
    raw_top[BIT_PWR_OK]    = st.top[0];
    raw_top[BIT_SYNC_CLK]  = st.top[1];
    raw_top[BIT_THERMAL]   = st.top[2];
    raw_top[BIT_LOAD_MEAS] = st.top[3];
  end

  // --------------------------------------------------------------
  // Edge detection of top events
  // --------------------------------------------------------------
  rsm_byte_t raw_top_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      raw_top_q <= ZERO_BYTE;
    end else begin
      raw_top_q <= raw_top;
    end
  end
  // Held off until the synchroniser and delay stage hold real levels,
  // so a pin that idles high gives no event after reset
  logic [SETTLE_EDGES-1:0] settle;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      settle <= '0;
    end else begin
      settle <= {settle[SETTLE_EDGES-2:0], 1'b1};
    end
  end
  wire logic      settled   = settle[SETTLE_EDGES-1];
  wire rsm_byte_t event_hit = settled ? ((raw_top ^ raw_top_q) & MASK_USED) : ZERO_BYTE;

  // --------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------
  wire logic sel_mask  = (reg_addr == ADDR_TOP_MASK);
  wire logic sel_flag  = (reg_addr == ADDR_EVENT_FLAG);
  wire logic wr_mask   = reg_wr && sel_mask;
  wire logic wr_flag   = reg_wr && sel_flag;

  // --------------------------------------------------------------
  // Mask register, factory value taken after reset release
  // --------------------------------------------------------------
  rsm_byte_t top_event_mask;
  logic      mask_loaded;
  rsm_byte_t next_mask;

  assign next_mask = !mask_loaded ? factory_mask :
                     wr_mask      ? reg_wdata    :
                                    top_event_mask;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      top_event_mask <= ZERO_BYTE;
      mask_loaded    <= 1'b0;
    end else begin
      top_event_mask <= next_mask;
      mask_loaded    <= 1'b1;
    end
  end

  // --------------------------------------------------------------
  // Latched event flags, write 1 to clear, set wins
  // --------------------------------------------------------------
  rsm_byte_t event_flags;
  wire rsm_byte_t clr_flags  = wr_flag ? reg_wdata : ZERO_BYTE;
  wire rsm_byte_t next_flags = (event_flags & ~clr_flags) | event_hit;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      event_flags <= ZERO_BYTE;
    end else begin
      event_flags <= next_flags;
    end
  end

  // --------------------------------------------------------------
  // Interrupt request
  // --------------------------------------------------------------
  // Bits 7, 4, 2, 0 of the mask gate the four events
  wire rsm_byte_t pending  = event_flags & ~top_event_mask & MASK_USED;
  wire logic      next_irq = |pending;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // --------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------
  rsm_byte_t rd_mux;
  always_comb begin
    case (reg_addr)
      ADDR_CONV_STAT:  rd_mux = conv_stat;
      ADDR_LIN_STAT:   rd_mux = lin_stat;
      ADDR_TOP_MASK:   rd_mux = top_event_mask;
      ADDR_EVENT_FLAG: rd_mux = event_flags;
      ADDR_RAW_TOP:    rd_mux = raw_top;
      default:         rd_mux = ZERO_BYTE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata  <= ZERO_BYTE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= reg_rd ? rd_mux : reg_rdata;
      reg_rvalid <= reg_rd;
    end
  end
endmodule
`default_nettype wire
